/* File: hdl/cec_encoder.sv */
// Design decisions made here: the register addresses and register access over APB.
`default_nettype none
// Compound error code encoder with correction filtering and APB access.
// One event at a time is encoded into the bank word that software reads.
module cec_encoder
   import cec_pkg::*;
(
   input wire logic clk_sys, // System clock, 25 MHz.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic evt_valid, // Error event strobe.
   input wire cec_evt_s evt, // Error event contents.
   output logic evt_ready, // Encoder can accept event.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr // APB error.
);
   // ==========================================================
   // Pipeline states: take event in idle, then look up counter and post in look.
   typedef enum logic [1:0]
   {
      CEC_ST_IDLE = 2'h1,
      CEC_ST_LOOK = 2'h2
   } cec_st_e;

   // The held event, the bank word and the suppressed tally are the only
   // wide state; the per-line counters live in the small memory below.
   cec_st_e st_q, st_d; // Encoder state.
   cec_evt_s ev_q, ev_d; // Held event.
   logic [31:0] status_q, status_d; // Bank error status word.
   logic [3:0] thresh_q, thresh_d; // Counter value up to which corrections are still posted.
   logic [15:0] suppr_q, suppr_d; // Count of suppressed corrections.
   logic [15:0] code; // Assembled compound code.
   logic filt; // Filter flag for this post.
   logic post; // Post this cycle.
   logic mem_we; // Counter update.
   logic [3:0] mem_wd; // New counter value.
   logic [3:0] cnt; // Counter for held line.
   logic [3:0] rq; // Sanitised request kind.
   logic [1:0] tk; // Sanitised transaction kind.
   logic [1:0] lv; // Sanitised level.
   logic [1:0] sp; // Sanitised space kind.
   logic wr_acc; // APB write access.

   // Per-line counters. The read index is the incoming event's line, so
   // the count is ready in the look-up cycle without an extra stage.
   cec_line_mem #(.DEPTH(CEC_LINES), .AW(4)) u_mem
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .we(mem_we),
      .waddr(ev_q.line),
      .wdata(mem_wd),
      .raddr(evt.line),
      .rdata(cnt)
   );

   // ==========================================================
   // Field sanitising and code assembly.
   // Every sub-field except the bus participation role and timeout bit is cleaned before it enters the word, so a source
   // that hands over an undefined encoding still yields a legal code.
   // Unknown transaction kinds and levels fall back to their generic codes.
   // The reserved space code is folded onto "other", since a posted word
   // must never carry it.
   // Eviction and snoop belong to caches alone; on the other forms they are
   // reported as the generic write or read that they most resemble.
   // The filter flag is raised only for corrections, so an uncorrected post
   // always leaves with the flag clear.
   // All four forms are built side by side and the source class picks one.
   always_comb
   begin
      tk = ev_q.tk_known ? ev_q.transaction_kind : CEC_TK_GEN;
      if (tk == 2'h3)
         tk = CEC_TK_GEN;
      lv = ev_q.lv_known ? ev_q.hierarchy_level_code : CEC_LV_GEN;
      rq = ev_q.request_kind;
      if (rq > CEC_RQ_SNOOP)
         rq = CEC_RQ_ERR; // Unknown action.
      else if (rq > CEC_RQ_FETCH_MAX && ev_q.cls != CEC_CLS_CACHE)
         rq = (rq == CEC_RQ_EVICT) ? CEC_RQ_WR : CEC_RQ_RD;
      sp = (ev_q.space_kind == CEC_SP_RSVD) ? CEC_SP_OTHER : ev_q.space_kind;
      filt = !ev_q.uncorr && (cnt >= thresh_q);
      code = 16'h0000;
      case (ev_q.cls)
         CEC_CLS_TLB: code = {3'h0, filt, CEC_TLB_MARK, tk, lv};
         CEC_CLS_CACHE: code = {3'h0, filt, CEC_CACHE_MARK, rq, tk, lv};
         CEC_CLS_BUS: code = {3'h0, filt, 1'b1, ev_q.participation_role, ev_q.timed_out, rq, sp, lv};
         default: code = {3'h0, filt, 8'h00, CEC_GEN_MARK, lv};
      endcase
   end

   // ==========================================================
   // Event flow and posting.
   // An event is taken in idle and looked up for one cycle while the
   // line counter read settles; the post lands at the following edge.
   // Taking events only every second cycle keeps the counter read and
   // its update from overlapping, at the cost of half the event rate.
   // A corrected event on a line past the threshold is counted instead
   // of posted; uncorrected events ignore the counter entirely.
   always_comb
   begin
      st_d = st_q;
      ev_d = ev_q;
      post = 1'b0;
      mem_we = 1'b0;
      mem_wd = cnt;
      suppr_d = suppr_q;
      status_d = status_q;
      thresh_d = thresh_q;
      wr_acc = psel && penable && pwrite;
      evt_ready = (st_q == CEC_ST_IDLE);
      case (st_q)
         CEC_ST_IDLE:
         begin
            if (evt_valid)
            begin
               // Keep a copy so the source may change its fields at once.
               ev_d = evt;
               st_d = CEC_ST_LOOK;
            end
         end
         CEC_ST_LOOK:
         begin
            st_d = CEC_ST_IDLE;
            if (ev_q.uncorr)
               post = 1'b1; // Never suppressed.
            else if (cnt > thresh_q)
               // Filtered correction: only the tally of dropped events moves.
               suppr_d = suppr_q + 16'h0001;
            else
            begin
               // Posted correction; the counter saturates so that a threshold of
               // fifteen leaves the line flagged rather than wrapping to zero.
               post = 1'b1;
               mem_we = (cnt != 4'hF);
               mem_wd = cnt + 4'h1;
            end
         end
         default: st_d = CEC_ST_IDLE;
      endcase
      // Software writes first; a post in the same cycle wins.
      // Losing a fresh post to a software clear would hide an error for good.
      if (wr_acc && paddr == CEC_OFF_STATUS)
         status_d = pwdata;
      if (wr_acc && paddr == CEC_OFF_CTRL)
         thresh_d = pwdata[3:0];
      if (post)
      begin
         status_d = 32'h0000_0000;
         status_d[15:0] = code;
         status_d[CEC_UNCORR_BIT] = ev_q.uncorr;
         status_d[CEC_VALID_BIT] = 1'b1;
      end
   end

   // State registers only; every next value comes from the process above.
   // Reset clears the bank word and the tally and restores the default
   // threshold, so software starts from an empty bank.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_q <= CEC_ST_IDLE;
         ev_q <= '0;
         status_q <= 32'h0000_0000;
         thresh_q <= CEC_THRESH_RST;
         suppr_q <= 16'h0000;
      end
      else
      begin
         st_q <= st_d;
         ev_q <= ev_d;
         status_q <= status_d;
         thresh_q <= thresh_d;
         suppr_q <= suppr_d;
      end
   end

   // ==========================================================
   // APB slave: zero wait, unmapped reads zero with error.
   // Reads come straight from the registers, so no wait state is needed
   // and pready stays high; software polls the bank word at leisure.
   // The suppressed count is read only; writes to it are dropped.
   always_comb
   begin
      pready = 1'b1;
      pslverr = psel && penable && !(paddr == CEC_OFF_STATUS || paddr == CEC_OFF_CTRL || paddr == CEC_OFF_LINE);
      case (paddr)
         CEC_OFF_STATUS: prdata = status_q;
         CEC_OFF_CTRL: prdata = {28'h0, thresh_q};
         CEC_OFF_LINE: prdata = {16'h0, suppr_q};
         default: prdata = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Checks.
   // The steps of one event: taken in idle, one look-up cycle, then idle.
   // Each step is a sequence so that the flow reads as it runs.
   sequence s_take;
      evt_valid && evt_ready;
   endsequence

   sequence s_look;
      st_q == CEC_ST_LOOK;
   endsequence

   sequence s_back_idle;
      st_q == CEC_ST_IDLE;
   endsequence

   // A corrected event on a line that has run past the threshold.
   sequence s_drop;
      st_q == CEC_ST_LOOK && !ev_q.uncorr && cnt > thresh_q;
   endsequence

   // A corrected event on a line that is still inside the threshold.
   sequence s_keep;
      st_q == CEC_ST_LOOK && !ev_q.uncorr && cnt <= thresh_q;
   endsequence

   // Flow and posting: every event leaves idle for exactly one cycle,
   // and what it posts or drops follows from its line counter.
   a_take_flow: assert property (@(posedge clk_sys) disable iff (srst)
      s_take |=> s_look ##1 s_back_idle)
      else $error("event flow broken");
   a_state_onehot: assert property (@(posedge clk_sys) disable iff (srst)
      $onehot(st_q))
      else $error("state not one-hot");
   a_valid_post: assert property (@(posedge clk_sys) disable iff (srst)
      post |=> status_q[CEC_VALID_BIT])
      else $error("post without valid flag");
   a_corr_flag: assert property (@(posedge clk_sys) disable iff (srst)
      (post && !ev_q.uncorr) |=> !status_q[CEC_UNCORR_BIT])
      else $error("corrected post marked uncorrected");
   a_uncorr_posted: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q == CEC_ST_LOOK && ev_q.uncorr) |=> status_q[CEC_VALID_BIT] && status_q[CEC_UNCORR_BIT])
      else $error("uncorrected event not posted");
   a_keep_posted: assert property (@(posedge clk_sys) disable iff (srst)
      s_keep |-> post)
      else $error("correction inside threshold dropped");
   a_drop_silent: assert property (@(posedge clk_sys) disable iff (srst)
      s_drop |=> $stable(status_q) || ($past(wr_acc) && $past(paddr) == CEC_OFF_STATUS))
      else $error("filtered correction was posted");
   a_drop_count: assert property (@(posedge clk_sys) disable iff (srst)
      s_drop |=> suppr_q == $past(suppr_q) + 16'h0001)
      else $error("filtered correction not counted");

   // Filter flag: raised on the last correction that is still posted,
   // clear before it and on every uncorrected post.
   a_filter_clear: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q == CEC_ST_LOOK && ev_q.uncorr) |=> !status_q[CEC_FILT_BIT])
      else $error("filter flag on uncorrected post");
   a_filt_last: assert property (@(posedge clk_sys) disable iff (srst)
      (post && !ev_q.uncorr && cnt == thresh_q) |=> status_q[CEC_FILT_BIT])
      else $error("last correction not flagged");
   a_filt_early: assert property (@(posedge clk_sys) disable iff (srst)
      (post && cnt < thresh_q) |=> !status_q[CEC_FILT_BIT])
      else $error("early correction flagged");

   // Code forms and sub-fields, checked on the word that each post leaves.
   // Fields copied from the event are compared with the event one cycle back.
   a_top_zero: assert property (@(posedge clk_sys) disable iff (srst)
      post |=> status_q[15:13] == 3'h0)
      else $error("code top bits not zero");
   a_gen_form: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_GEN) |=> status_q[11:2] == 10'h003)
      else $error("generic form wrong");
   a_tlb_form: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_TLB) |=> status_q[11:4] == CEC_TLB_MARK && status_q[3:2] != 2'h3)
      else $error("tlb form wrong");
   a_cache_form: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_CACHE) |=> status_q[11:8] == CEC_CACHE_MARK && status_q[7:4] <= CEC_RQ_SNOOP)
      else $error("cache form wrong");
   a_bus_noevict: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_BUS) |=> status_q[11] && status_q[7:4] <= CEC_RQ_FETCH_MAX)
      else $error("bus form wrong");
   a_tk_legal: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_CACHE) |=> status_q[3:2] != 2'h3)
      else $error("cache transaction kind illegal");
   a_tk_gen: assert property (@(posedge clk_sys) disable iff (srst)
      (post && !ev_q.tk_known && (ev_q.cls == CEC_CLS_TLB || ev_q.cls == CEC_CLS_CACHE))
         |=> status_q[3:2] == CEC_TK_GEN)
      else $error("unknown transaction kind not generic");
   a_level_gen: assert property (@(posedge clk_sys) disable iff (srst)
      (post && !ev_q.lv_known) |=> status_q[1:0] == CEC_LV_GEN)
      else $error("unknown level not generic");
   a_level_copy: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.lv_known) |=> status_q[1:0] == $past(ev_q.hierarchy_level_code))
      else $error("known level not copied");
   a_req_unknown: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.request_kind > CEC_RQ_SNOOP && ev_q.cls inside {CEC_CLS_CACHE, CEC_CLS_BUS})
         |=> status_q[7:4] == CEC_RQ_ERR)
      else $error("unknown request not generic error");
   a_role_copy: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_BUS) |=> status_q[10:9] == $past(ev_q.participation_role))
      else $error("participation role wrong");
   a_timeout_bit: assert property (@(posedge clk_sys) disable iff (srst)
      (post && ev_q.cls == CEC_CLS_BUS) |=> status_q[8] == $past(ev_q.timed_out))
      else $error("timeout bit wrong");
   a_space_legal: assert property (@(posedge clk_sys) disable iff (srst)
      (status_q[11] && status_q[CEC_VALID_BIT]) |-> status_q[3:2] != CEC_SP_RSVD)
      else $error("reserved space kind posted");
endmodule : cec_encoder
`default_nettype wire

/* File: hdl/cec_pkg.sv */
`default_nettype none
package cec_pkg;
   // ==========================================================
   // Register map and fields.
   localparam logic [11:0] CEC_OFF_STATUS = 12'h000;
   localparam logic [11:0] CEC_OFF_CTRL = 12'h004;
   localparam logic [11:0] CEC_OFF_LINE = 12'h008;
   localparam int CEC_VALID_BIT = 31;
   localparam int CEC_UNCORR_BIT = 30;
   localparam int CEC_FILT_BIT = 12;
   localparam logic [3:0] CEC_THRESH_RST = 4'h3;
   localparam int CEC_LINES = 16;
   // ==========================================================
   // Sub-field encodings.
   localparam logic [1:0] CEC_TK_INSTR = 2'h0;
   localparam logic [1:0] CEC_TK_DATA = 2'h1;
   localparam logic [1:0] CEC_TK_GEN = 2'h2;
   localparam logic [1:0] CEC_LV_GEN = 2'h3;
   localparam logic [3:0] CEC_RQ_ERR = 4'h0;
   localparam logic [3:0] CEC_RQ_RD = 4'h1;
   localparam logic [3:0] CEC_RQ_WR = 4'h2;
   localparam logic [3:0] CEC_RQ_FETCH_MAX = 4'h6;
   localparam logic [3:0] CEC_RQ_EVICT = 4'h7;
   localparam logic [3:0] CEC_RQ_SNOOP = 4'h8;
   localparam logic [1:0] CEC_ROLE_GEN = 2'h3;
   localparam logic [1:0] CEC_SP_RSVD = 2'h1;
   localparam logic [1:0] CEC_SP_OTHER = 2'h3;
   localparam logic [7:0] CEC_TLB_MARK = 8'h01;
   localparam logic [3:0] CEC_CACHE_MARK = 4'h1;
   localparam logic [1:0] CEC_GEN_MARK = 2'h3;

   // Error source classes; one-hot.
   typedef enum logic [3:0]
   {
      CEC_CLS_GEN = 4'h1,
      CEC_CLS_TLB = 4'h2,
      CEC_CLS_CACHE = 4'h4,
      CEC_CLS_BUS = 4'h8
   } cec_cls_e;

   // One error event from a core source.
   typedef struct packed {
      cec_cls_e cls; // Source class.
      logic uncorr; // Uncorrected error.
      logic tk_known; // Transaction kind is known.
      logic [1:0] transaction_kind;
      logic lv_known; // Level is known.
      logic [1:0] hierarchy_level_code;
      logic [3:0] request_kind; // Sanitised by encoder.
      logic [1:0] participation_role;
      logic timed_out;
      logic [1:0] space_kind;
      logic [3:0] line; // Line or entry index.
   } cec_evt_s;
endpackage : cec_pkg
`default_nettype wire

/* File: hdl/cec_line_mem.sv */
`default_nettype none
// Per-line correction counters; read data is registered.
module cec_line_mem
   import cec_pkg::*;
#(
   parameter int DEPTH = CEC_LINES,
   parameter int AW = 4
)
(
   input wire logic clk_sys, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic we, // Write strobe.
   input wire logic [AW-1:0] waddr, // Write index.
   input wire logic [3:0] wdata, // Write count.
   input wire logic [AW-1:0] raddr, // Read index.
   output logic [3:0] rdata // Registered read data.
);
   // ==========================================================
   // Storage.
   logic [3:0] mem_q [DEPTH];

   // Counters clear at reset so filtering restarts cleanly.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem_q[i] <= 4'h0;
         rdata <= 4'h0;
      end
      else
      begin
         if (we)
            mem_q[waddr] <= wdata;
         rdata <= mem_q[raddr];
      end
   end
endmodule : cec_line_mem
`default_nettype wire

/* File: testbench/cec_encoder_tb_top.sv */
`default_nettype none
module cec_encoder_tb_top import cec_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Stimulus and observed signals.
   logic clk_sys = 1'b0; // Bench clock.
   logic srst = 1'b1; // Held for five cycles at start.
   logic evt_valid = 1'b0; // Event strobe.
   cec_evt_s evt = '0; // Event fields.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus controls.
   logic [11:0] paddr = 12'h000; // Bus address.
   logic [31:0] pwdata = 32'h0, prdata, rd; // Bus data.
   logic evt_ready, pready, pslverr, er; // Handshakes.
   int errors = 0, n_tests = 0; // Mismatches and comparisons.
   int ln = 0; // Next free line, so table cases never meet the filter.

   cec_encoder u_cec_encoder (.clk_sys(clk_sys), .srst(srst), .evt_valid(evt_valid), .evt(evt),
      .evt_ready(evt_ready), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 25 MHz clock.
   always #20 clk_sys = ~clk_sys;

   // ==========================================================
   // Reporting.
   task summarize();
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // Compares one value; four-state so an unknown never matches.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // ==========================================================
   // Bus cycles; the request is held until pready is seen at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         errors++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Offers one event and waits for it to be taken, then for the post.
   task snd(input cec_cls_e c, input logic [1:0] tk, lv, input logic [3:0] rq, input logic [1:0] ro,
      input logic to, input logic [1:0] sp, input logic k, input logic u, input logic [3:0] l);
      int n;
      @(posedge clk_sys);
      evt_valid <= 1'b1;
      evt <= '{cls: c, uncorr: u, tk_known: k, transaction_kind: tk, lv_known: k, hierarchy_level_code: lv,
         request_kind: rq, participation_role: ro, timed_out: to, space_kind: sp, line: l};
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (evt_ready !== 1'b1 && n < 50);
      if (evt_ready !== 1'b1)
      begin
         errors++;
         summarize();
      end
      evt_valid <= 1'b0;
      @(posedge clk_sys);
      check({31'h0, evt_ready}, 32'h0);
      repeat (2) @(posedge clk_sys);
   endtask : snd

   // Clears status, posts one corrected event on a fresh line, checks the word.
   task cs(input cec_cls_e c, input logic [1:0] tk, lv, input logic [3:0] rq, input logic [1:0] ro,
      input logic to, input logic [1:0] sp, input logic k, input logic [15:0] code);
      apb(1'b1, CEC_OFF_STATUS, 32'h0);
      snd(c, tk, lv, rq, ro, to, sp, k, 1'b0, 4'(ln));
      ln++;
      apb(1'b0, CEC_OFF_STATUS, 32'h0);
      check(rd, {16'h8000, code});
   endtask : cs

   // ==========================================================
   // Main sequence.
   initial
   begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      apb(1'b0, CEC_OFF_STATUS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, CEC_OFF_LINE, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, CEC_OFF_CTRL, 32'h0);
      check(rd, 32'h3);
      apb(1'b0, 12'h00C, 32'h0);
      check({31'h0, er}, 32'h1);
      cs(CEC_CLS_GEN, 2'h0, 2'h2, 4'h0, 2'h0, 1'b0, 2'h0, 1'b1, 16'h000E);
      cs(CEC_CLS_TLB, 2'h1, 2'h1, 4'h0, 2'h0, 1'b0, 2'h0, 1'b1, 16'h0015);
      cs(CEC_CLS_TLB, 2'h0, 2'h0, 4'h0, 2'h0, 1'b0, 2'h0, 1'b0, 16'h001B);
      cs(CEC_CLS_TLB, 2'h3, 2'h0, 4'h0, 2'h0, 1'b0, 2'h0, 1'b1, 16'h0018);
      cs(CEC_CLS_CACHE, 2'h0, 2'h0, 4'h8, 2'h0, 1'b0, 2'h0, 1'b1, 16'h0180);
      cs(CEC_CLS_CACHE, 2'h2, 2'h3, 4'h7, 2'h0, 1'b0, 2'h0, 1'b1, 16'h017B);
      cs(CEC_CLS_CACHE, 2'h1, 2'h2, 4'h9, 2'h0, 1'b0, 2'h0, 1'b1, 16'h0106);
      cs(CEC_CLS_BUS, 2'h0, 2'h1, 4'h3, 2'h1, 1'b1, 2'h2, 1'b1, 16'h0B39);
      cs(CEC_CLS_BUS, 2'h0, 2'h3, 4'h7, 2'h2, 1'b0, 2'h1, 1'b1, 16'h0C2F);
      cs(CEC_CLS_BUS, 2'h0, 2'h0, 4'h5, 2'h3, 1'b0, 2'h0, 1'b1, 16'h0E50);
      cs(CEC_CLS_BUS, 2'h0, 2'h2, 4'h8, 2'h0, 1'b0, 2'h3, 1'b1, 16'h081E);
      // Repeated corrections on one line: the last post flags, later ones vanish.
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, CEC_OFF_STATUS, 32'h0);
         snd(CEC_CLS_CACHE, 2'h1, 2'h1, 4'h3, 2'h0, 1'b0, 2'h0, 1'b1, 1'b0, 4'hF);
         apb(1'b0, CEC_OFF_STATUS, 32'h0);
         check(rd, (i > 3) ? 32'h0 : ((i == 3) ? 32'h8000_1135 : 32'h8000_0135));
      end
      apb(1'b0, CEC_OFF_LINE, 32'h0);
      check(rd, 32'h2);
      snd(CEC_CLS_CACHE, 2'h1, 2'h1, 4'h3, 2'h0, 1'b0, 2'h0, 1'b1, 1'b1, 4'hF);
      apb(1'b0, CEC_OFF_STATUS, 32'h0);
      check(rd, 32'hC000_0135);
      apb(1'b1, CEC_OFF_CTRL, 32'h5);
      apb(1'b0, CEC_OFF_CTRL, 32'h0);
      check(rd, 32'h5);
      summarize();
   end
endmodule : cec_encoder_tb_top
`default_nettype wire
